/* inc/pkfp_pkg.sv */
// Purpose: Shared constants and types for the pulse keyed fuse programmer.
// Assumes: One 100 MHz clock; supply-pin level comparators arrive as raw levels.
// Notes: Fuse vector packs magnitude, polarity and output/lock fields.
package pkfp_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TRY_W = 8;
  localparam int unsigned FUSE_W = 14;
  localparam logic [7:0] TRY_ENTRY_CODE = 8'h01;
  localparam logic [7:0] FUSE_ENTRY_ADDR = 8'h01;
  localparam logic [7:0] CHK_LOW_CODE = 8'h08;
  localparam logic [7:0] CHK_HIGH_CODE = 8'h09;
  localparam logic [3:0] KEY_POLSEL_MIDS = 4'h1;
  localparam logic [3:0] KEY_OUT_MIDS = 4'h3;
  localparam logic [3:0] KEY_DOWN_MIDS = 4'h4;
  localparam logic [3:0] KEY_MODE_MIDS = 4'hb;
  localparam logic [3:0] MIDS_MAX = 4'hf;
  localparam int unsigned FUSE_MAG_LSB = 0;
  localparam int unsigned FUSE_MAG_W = 8;
  localparam int unsigned FUSE_POL_BIT = 8;
  localparam int unsigned FUSE_OUT_LSB = 9;
  localparam int unsigned FUSE_OUT_W = 5;
  localparam int unsigned OUT_FALL_LSB = 0;
  localparam int unsigned OUT_SENSE_BIT = 2;
  localparam int unsigned OUT_LOCK_BIT = 4;
  localparam logic [FUSE_W-1:0] FUSE_RESET = 14'h0000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_H = 4'h1,
    ST_HM = 4'h2,
    ST_HMH = 4'h3,
    ST_POLF = 4'h4,
    ST_POS_UP = 4'h5,
    ST_NEG_UP = 4'h6,
    ST_POS_DN = 4'h7,
    ST_NEG_DN = 4'h8,
    ST_OUT_TRY = 4'h9,
    ST_FUSE = 4'ha,
    ST_DONE = 4'hb,
    ST_DEAD = 4'hc
  } pkfp_key_type;

  typedef enum logic [1:0] {
    FREG_MAG = 2'h0,
    FREG_POL = 2'h1,
    FREG_OUT = 2'h2
  } pkfp_freg_type;
endpackage : pkfp_pkg

/* inc/pkfp_sym_if.sv */
// Purpose: Carries classified supply-pin symbols from classifier to decoder.
// Assumes: Both ends on clk_sys_i.
// Notes: sym_vld is a one-cycle pulse at the end of each pulse.
`timescale 1ns/1ps
interface pkfp_sym_if;
  logic sym_vld;
  logic sym_high;
  modport src (output sym_vld, output sym_high);
  modport snk (input sym_vld, input sym_high);
endinterface : pkfp_sym_if

/* core/pkfp_pulse_class.sv */
// Purpose: Turns supply comparator levels into high-level or mid-level symbols.
// Assumes: Comparator levels are asynchronous to clk_sys_i.
// Notes: A symbol is emitted at the falling edge of the mid comparator.
`timescale 1ns/1ps
module pkfp_pulse_class
  import pkfp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Comparator levels
  input wire logic above_mid_i,
  input wire logic above_high_i,
  // Symbols
  pkfp_sym_if.src sym
);
  typedef struct packed {
    logic mid_s1;
    logic mid_s2;
    logic mid_d;
    logic hi_s1;
    logic hi_s2;
    logic seen_hi;
    logic vld;
    logic high;
  } pkfp_cls_type;

  pkfp_cls_type s_q;
  pkfp_cls_type s_d;

  always_comb
  begin
    s_d = s_q;
    s_d.mid_s1 = above_mid_i;
    s_d.mid_s2 = s_q.mid_s1;
    s_d.hi_s1 = above_high_i;
    s_d.hi_s2 = s_q.hi_s1;
    s_d.mid_d = s_q.mid_s2;
    // A pulse that reached the high level anywhere counts as high
    s_d.seen_hi = s_q.mid_s2 ? (s_q.seen_hi | s_q.hi_s2) : 1'b0;
    s_d.vld = s_q.mid_d & ~s_q.mid_s2;
    s_d.high = s_q.seen_hi | s_q.hi_s2;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sym.sym_vld = s_q.vld;
  assign sym.sym_high = s_q.high;
endmodule : pkfp_pulse_class

/* core/pkfp_top.sv */
// Purpose: Key decoder, trial registers and fuse blow/read control.
// Assumes: srst_i follows supply power cycling; fuse_blown_i is stable fuse sense.
// Notes: Blow pulse duration and analog thresholds are handled outside.
`timescale 1ns/1ps
module pkfp_top
  import pkfp_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // Supply pin comparators
  input wire logic above_mid_i,
  input wire logic above_high_i,
  // Fuse array
  input wire logic [FUSE_W-1:0] fuse_blown_i,
  output logic blow_strobe_o,
  output logic [FUSE_W-1:0] blow_sel_o,
  // Switch settings
  output logic [TRY_W-1:0] op_magnitude_o,
  output logic op_north_o,
  output logic [1:0] fall_time_o,
  output logic output_sense_bit_o,
  output logic chk_low_o,
  output logic chk_high_o,
  // Output pin, open drain
  output logic switch_output_pin_o,
  output logic switch_output_pin_oe_o
);
  typedef struct packed {
    pkfp_key_type st;
    pkfp_freg_type freg;
    logic [3:0] mids;
    logic [TRY_W-1:0] code;
    logic [7:0] addr;
    logic [FUSE_W-1:0] fb;
    logic blow;
    logic [FUSE_W-1:0] bsel;
    logic [TRY_W-1:0] mag;
    logic north;
    logic [1:0] fall;
    logic sense;
    logic chk_lo;
    logic chk_hi;
    logic pin_oe;
  } pkfp_state_type;

  pkfp_sym_if sym ();
  pkfp_state_type s_q;
  pkfp_state_type s_d;
  logic locked;

  pkfp_pulse_class u_class (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .above_mid_i(above_mid_i),
    .above_high_i(above_high_i),
    .sym(sym.src)
  );

  function automatic logic [7:0] fuse_field(input logic [FUSE_W-1:0] fb, input pkfp_freg_type fr);
    logic [7:0] v;
    v = 8'h00;
    case (fr)
      FREG_MAG: v = fb[FUSE_MAG_LSB +: FUSE_MAG_W];
      FREG_POL: v = {7'h00, fb[FUSE_POL_BIT]};
      FREG_OUT: v = {3'h0, fb[FUSE_OUT_LSB +: FUSE_OUT_W]};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : fuse_field

  function automatic logic [FUSE_W-1:0] blow_map(input pkfp_freg_type fr, input logic [7:0] a);
    logic [FUSE_W-1:0] m;
    m = '0;
    case (fr)
      FREG_MAG: m[FUSE_MAG_LSB +: FUSE_MAG_W] = a;
      FREG_POL: m[FUSE_POL_BIT] = a[0];
      FREG_OUT: m[FUSE_OUT_LSB +: FUSE_OUT_W] = a[FUSE_OUT_W-1:0];
      default: m = '0;
    endcase
    return m;
  endfunction : blow_map

  function automatic logic [3:0] mids_inc(input logic [3:0] m);
    return (m == MIDS_MAX) ? m : m + 4'h1;
  endfunction : mids_inc

  assign locked = s_q.fb[FUSE_OUT_LSB + OUT_LOCK_BIT];

  always_comb
  begin
    s_d = s_q;
    s_d.fb = fuse_blown_i;
    s_d.blow = 1'b0;
    s_d.bsel = '0;
    if (sym.sym_vld)
    begin
      case (s_q.st)
        ST_IDLE: s_d.st = sym.sym_high ? ST_H : ST_DEAD;
        ST_H:
        begin
          if (sym.sym_high)
          begin
            s_d.st = locked ? ST_DEAD : ST_POS_UP;
            s_d.code = TRY_ENTRY_CODE;
            s_d.mids = '0;
          end
          else
          begin
            s_d.st = ST_HM;
            s_d.mids = 4'h1;
          end
        end
        ST_HM:
        begin
          if (!sym.sym_high)
            s_d.mids = mids_inc(s_q.mids);
          else if (s_q.mids == KEY_POLSEL_MIDS)
            s_d.st = ST_HMH;
          else if (s_q.mids == KEY_OUT_MIDS)
          begin
            s_d.st = ST_OUT_TRY;
            s_d.code = TRY_ENTRY_CODE;
            s_d.mids = '0;
          end
          else
            s_d.st = ST_DEAD;
        end
        ST_HMH:
        begin
          if (sym.sym_high)
          begin
            s_d.st = locked ? ST_DEAD : ST_NEG_UP;
            s_d.code = TRY_ENTRY_CODE;
            s_d.mids = '0;
          end
          else
          begin
            s_d.st = ST_POLF;
            s_d.mids = 4'h1;
          end
        end
        ST_POLF:
        begin
          if (!sym.sym_high)
            s_d.mids = mids_inc(s_q.mids);
          else if (s_q.mids == KEY_MODE_MIDS && !locked)
          begin
            s_d.st = ST_FUSE;
            s_d.freg = FREG_POL;
            s_d.addr = FUSE_ENTRY_ADDR;
          end
          else
            s_d.st = ST_DEAD;
        end
        ST_POS_UP, ST_NEG_UP:
        begin
          if (!sym.sym_high)
          begin
            s_d.code = s_q.code + 8'h01;
            s_d.mids = mids_inc(s_q.mids);
          end
          else if (s_q.mids == KEY_DOWN_MIDS)
          begin
            s_d.st = (s_q.st == ST_POS_UP) ? ST_POS_DN : ST_NEG_DN;
            s_d.code = TRY_ENTRY_CODE;
            s_d.mids = '0;
          end
          else if (s_q.mids == KEY_MODE_MIDS && s_q.st == ST_POS_UP)
          begin
            s_d.st = ST_FUSE;
            s_d.freg = FREG_MAG;
            s_d.addr = FUSE_ENTRY_ADDR;
          end
          else
            s_d.st = ST_DEAD;
        end
        ST_POS_DN, ST_NEG_DN:
        begin
          if (!sym.sym_high)
            s_d.code = s_q.code + 8'h01;
          else
            s_d.st = ST_DEAD;
        end
        ST_OUT_TRY:
        begin
          if (!sym.sym_high)
          begin
            s_d.code = s_q.code + 8'h01;
            s_d.mids = mids_inc(s_q.mids);
          end
          else if (s_q.mids == KEY_MODE_MIDS && !locked)
          begin
            s_d.st = ST_FUSE;
            s_d.freg = FREG_OUT;
            s_d.addr = FUSE_ENTRY_ADDR;
          end
          else
            s_d.st = ST_DEAD;
        end
        ST_FUSE:
        begin
          if (!sym.sym_high)
            s_d.addr = {s_q.addr[6:0], 1'b0};
          else
          begin
            // Only the one addressed bit is fired, then wait for power cycle
            s_d.blow = 1'b1;
            s_d.bsel = blow_map(s_q.freg, s_q.addr);
            s_d.st = ST_DONE;
          end
        end
        ST_DONE, ST_DEAD: s_d.st = s_q.st;
        default: s_d.st = ST_DEAD;
      endcase
    end
    // Trial values only raise bits above what is already blown
    case (s_d.st)
      ST_POS_UP, ST_NEG_UP: s_d.mag = s_d.fb[FUSE_MAG_LSB +: FUSE_MAG_W] | s_d.code;
      ST_POS_DN, ST_NEG_DN: s_d.mag = s_d.fb[FUSE_MAG_LSB +: FUSE_MAG_W] | ~s_d.code;
      default: s_d.mag = s_d.fb[FUSE_MAG_LSB +: FUSE_MAG_W];
    endcase
    s_d.north = s_d.fb[FUSE_POL_BIT] | (s_d.st == ST_NEG_UP) | (s_d.st == ST_NEG_DN);
    s_d.fall = s_d.fb[FUSE_OUT_LSB + OUT_FALL_LSB +: 2];
    s_d.sense = s_d.fb[FUSE_OUT_LSB + OUT_SENSE_BIT];
    if (s_d.st == ST_OUT_TRY && !s_d.fb[FUSE_OUT_LSB + OUT_LOCK_BIT])
    begin
      s_d.fall = s_d.fall | s_d.code[OUT_FALL_LSB +: 2];
      s_d.sense = s_d.sense | s_d.code[OUT_SENSE_BIT];
    end
    s_d.chk_lo = (s_d.st == ST_OUT_TRY) && (s_d.code == CHK_LOW_CODE);
    s_d.chk_hi = (s_d.st == ST_OUT_TRY) && (s_d.code == CHK_HIGH_CODE);
    // Pin is pulled low only for a blown addressed fuse, polarity ignored
    s_d.pin_oe = (s_d.st == ST_FUSE) && |(fuse_field(s_d.fb, s_d.freg) & s_d.addr);
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign blow_strobe_o = s_q.blow;
  assign blow_sel_o = s_q.bsel;
  assign op_magnitude_o = s_q.mag;
  assign op_north_o = s_q.north;
  assign fall_time_o = s_q.fall;
  assign output_sense_bit_o = s_q.sense;
  assign chk_low_o = s_q.chk_lo;
  assign chk_high_o = s_q.chk_hi;
  assign switch_output_pin_o = 1'b0;
  assign switch_output_pin_oe_o = s_q.pin_oe;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  a_try_entry_one: assert property ((s_q.st == ST_H) && sym.sym_vld && sym.sym_high && !locked |=>
    (s_q.st == ST_POS_UP) && (s_q.code == 8'h01)) else $error("Trial entry code not 1");
  a_up_wrap_zero: assert property ((s_q.st inside {ST_POS_UP, ST_NEG_UP}) && sym.sym_vld && !sym.sym_high &&
    (s_q.code == 8'hff) |=> (s_q.code == 8'h00)) else $error("Up trial code did not wrap");
  a_down_inverts: assert property ((s_q.st == ST_POS_DN) |->
    (op_magnitude_o == (s_q.fb[7:0] | ~s_q.code))) else $error("Down trial not inverted");
  a_fuse_preset: assert property ((s_q.st != ST_FUSE) ##1 (s_q.st == ST_FUSE) |->
    (s_q.addr == 8'h01)) else $error("Fuse address not preset to bit 0");
  a_blow_single: assert property (blow_strobe_o |-> $onehot(blow_sel_o) &&
    ($past(s_q.st) == ST_FUSE) ##1 !blow_strobe_o) else $error("Blow not one-hot single");
  a_read_pin: assert property ((s_q.st == ST_FUSE) |->
    (switch_output_pin_oe_o == |(fuse_field(s_q.fb, s_q.freg) & s_q.addr))) else $error("Read pin wrong");
  a_lock_refuse: assert property (locked && $stable(locked) |->
    (s_q.st != ST_FUSE) && !blow_strobe_o) else $error("Access while locked");
  a_check_codes: assert property ((chk_low_o || chk_high_o) |-> (s_q.st == ST_OUT_TRY) &&
    (s_q.code == (chk_low_o ? 8'h08 : 8'h09))) else $error("Check enable wrong code");
  a_dead_sticks: assert property ((s_q.st == ST_DEAD) |=> (s_q.st == ST_DEAD)[*3])
    else $error("Dead key state left");

  c_blow_done: cover property (blow_strobe_o);
  c_read_blown: cover property ((s_q.st == ST_FUSE) && switch_output_pin_oe_o);
  c_neg_down: cover property (s_q.st == ST_NEG_DN);
  c_check_high: cover property (chk_high_o);
endmodule : pkfp_top

/* test/pkfp_prog_model.sv */
// Purpose: Behavioural programmer that pulses the supply pin of the fuse programmer.
// Assumes: Comparator levels switch cleanly once per pulse.
// Notes: Output pin is read through a modelled pull-up.
`timescale 1ns/1ps
module pkfp_prog_model
(
  // Clock
  input wire logic clk_sys_i,
  // Supply comparators
  output logic above_mid_o,
  output logic above_high_o,
  // Output pin
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic pin_level_o
);
  initial
  begin
    above_mid_o = 1'b0;
    above_high_o = 1'b0;
  end

  // Released pin floats up to the load resistor, never a stale value
  assign pin_level_o = pin_oe_i ? pin_i : 1'b1;

  // Five cycles up, six down: clear of the three-cycle minimums
  task automatic pulse(input bit high);
    @(posedge clk_sys_i);
    #1;
    above_mid_o = 1'b1;
    above_high_o = high;
    repeat (5) @(posedge clk_sys_i);
    #1;
    above_mid_o = 1'b0;
    above_high_o = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    // Return off the edge so callers never sample in the launching time step
    #1;
  endtask : pulse

  // H is a high-level pulse, anything else a mid-level pulse
  task automatic key(input string s);
    for (int i = 0; i < s.len(); i++)
      pulse(s.getc(i) == "H");
  endtask : key

  task automatic mids(input int n);
    repeat (n) pulse(1'b0);
  endtask : mids
endmodule : pkfp_prog_model

/* test/testbench.sv */
// Purpose: Self-checking bench for the pulse keyed fuse programmer.
// Assumes: Fuse sense is driven by the bench; reset stands for a power cycle.
// Notes: Expected settings come from an integer model of keys and codes.
`timescale 1ns/1ps
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      errors++; \
      $display("MISMATCH %0t got %h exp %h", $time, got, exp); \
    end \
  end
module testbench;
  import pkfp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [FUSE_W-1:0] fuse_q;
  logic above_mid, above_high, pin_level, blow_strobe, op_north, out_sense, chk_lo, chk_hi, pin, pin_oe;
  logic [FUSE_W-1:0] blow_sel, sel_seen;
  logic [7:0] op_mag, m8;
  logic [1:0] fall;
  int errors = 0;
  int total_checks = 0;
  int nstrobe = 0;
  int code, n, k;
  string trial_key[4] = '{"HH", "HMHH", "HHMMMMH", "HMHHMMMMH"};
  string freg_pre[3] = '{"HH", "HMH", "HMMMH"};
  int freg_base[3] = '{0, 8, 9};
  int freg_w[3] = '{8, 1, 5};

  initial
    forever #(CLK_PERIOD_NS / 2) clk_sys_i = ~clk_sys_i;

  pkfp_top uut (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i), .above_mid_i(above_mid), .above_high_i(above_high),
    .fuse_blown_i(fuse_q), .blow_strobe_o(blow_strobe), .blow_sel_o(blow_sel),
    .op_magnitude_o(op_mag), .op_north_o(op_north), .fall_time_o(fall),
    .output_sense_bit_o(out_sense), .chk_low_o(chk_lo), .chk_high_o(chk_hi),
    .switch_output_pin_o(pin), .switch_output_pin_oe_o(pin_oe)
  );

  pkfp_prog_model prog (
    .clk_sys_i(clk_sys_i), .above_mid_o(above_mid), .above_high_o(above_high),
    .pin_i(pin), .pin_oe_i(pin_oe), .pin_level_o(pin_level)
  );

  // Strobe lasts one cycle, so it is caught on the settled half
  always @(negedge clk_sys_i)
    if (blow_strobe === 1'b1)
    begin
      nstrobe++;
      sel_seen = blow_sel;
    end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test

  task automatic power_cycle(input logic [FUSE_W-1:0] f);
    @(posedge clk_sys_i);
    #1;
    srst_i = 1'b1;
    fuse_q = f;
    repeat (10) @(posedge clk_sys_i);
    #1;
    srst_i = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1;
    nstrobe = 0;
  endtask : power_cycle

  // Trial values are ORed with blown fuses
  task automatic chk_set(input logic [7:0] mag, input logic north, input logic [1:0] fl, input logic sense);
    `CHK(op_mag, mag | fuse_q[7:0])
    `CHK(op_north, north | fuse_q[8])
    `CHK(fall, fl | fuse_q[10:9])
    `CHK(out_sense, sense | fuse_q[11])
  endtask : chk_set

  function automatic logic [FUSE_W-1:0] rnd_fuse(input logic lock);
    logic [FUSE_W-1:0] v;
    v = FUSE_W'($urandom);
    v[13] = lock;
    return v;
  endfunction : rnd_fuse

  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    void'($urandom(26));
    power_cycle(rnd_fuse(1'b0));
    chk_set(8'h00, 1'b0, 2'b00, 1'b0);
    `CHK(pin_level, 1'b1)
    $display("reset test done");
    for (int m = 0; m < 4; m++)
    begin
      power_cycle(rnd_fuse(1'b0) & 14'h1800);
      prog.key(trial_key[m]);
      code = 1;
      n = (m == 0) ? 257 : $urandom_range(3, 20);
      for (int i = 0; i < n; i++)
      begin
        m8 = 8'(code);
        chk_set((m >= 2) ? ~m8 : m8, m[0], 2'b00, 1'b0);
        prog.mids(1);
        code = (code + 1) % 256;
      end
      $display("trial mode %0d done", m);
    end
    for (int c = 1; c <= 9; c++)
    begin
      power_cycle(rnd_fuse(1'b0) & 14'h00ff);
      prog.key("HMMMH");
      prog.mids(c - 1);
      if (c < 8)
        chk_set(8'h00, 1'b0, 2'(c), c[2]);
      `CHK(chk_lo, 1'(c == 8))
      `CHK(chk_hi, 1'(c == 9))
    end
    $display("output trial test done");
    for (int r = 0; r < 3; r++)
    begin
      power_cycle(rnd_fuse(1'b0));
      prog.key({freg_pre[r], "MMMMMMMMMMMH"});
      for (int i = 0; i < freg_w[r]; i++)
      begin
        `CHK(pin_level, ~fuse_q[freg_base[r] + i])
        prog.mids(1);
      end
      `CHK(nstrobe, 0)
      k = $urandom_range(0, freg_w[r] - 1);
      power_cycle(rnd_fuse(1'b0));
      prog.key({freg_pre[r], "MMMMMMMMMMMH"});
      prog.mids(k);
      prog.pulse(1'b1);
      `CHK(nstrobe, 1)
      `CHK(sel_seen, FUSE_W'(1) << (freg_base[r] + k))
      $display("fuse register %0d done", r);
    end
    power_cycle(14'h2000);
    prog.key("HH");
    chk_set(8'h00, 1'b0, 2'b00, 1'b0);
    power_cycle(14'h2000);
    prog.key("HHMMMMMMMMMMMH");
    prog.mids(1);
    prog.pulse(1'b1);
    `CHK(nstrobe, 0)
    `CHK(pin_level, 1'b1)
    power_cycle(14'h2000);
    prog.key("HMMMH");
    prog.mids(7);
    `CHK(chk_lo, 1'b1)
    $display("lock test done");
    power_cycle(rnd_fuse(1'b0));
    prog.key("HMMHHH");
    chk_set(8'h00, 1'b0, 2'b00, 1'b0);
    `CHK(chk_lo, 1'b0)
    $display("unknown key test done");
    finish_test();
  end
endmodule : testbench
